// ---- fbo_pkg.sv ----
// package: constants and carrier types for the flash bus controller
package fbo_pkg;
    // ======================================================
    // bus geometry
    localparam int ADDR_W = 21;           // address inputs
    localparam int DATA_W = 8;            // byte-wide data bus
    localparam int SECT_LSB = 16;         // lowest sector-select address bit
    localparam int BIT_SIX = 6;           // protect/unprotect select bit
    localparam int BIT_ONE = 1;           // must be high for protect ops
    localparam int BIT_ZERO = 0;          // must be low for protect ops
    // ======================================================
    // timing (200 MHz reference)
    localparam int CLK_PS = 5000;         // clock period in ps
    localparam int ACC_NS = 70;           // access time, least wait before sampling
    localparam int WP_NS = 35;            // write pulse width
    localparam int RP_NS = 500;           // reset pulse width
    localparam int RH_NS = 50;            // reset recovery before first access
    localparam int ACC_CYC = (ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WP_CYC = (WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RP_CYC = (RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RH_CYC = (RH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 8;             // width of the phase counter
    // ======================================================
    // request kinds
    typedef enum logic [2:0]
    {
        FBO_OP_READ = 3'h0,               // array / autoselect / status read
        FBO_OP_WRITE = 3'h1,              // command write cycle
        FBO_OP_RESET = 3'h2,              // hardware reset pulse
        FBO_OP_PROTECT = 3'h3,            // sector protect (high-voltage reset)
        FBO_OP_UNPROTECT = 3'h4           // sector unprotect
    } fbo_op_t;
    // request carrier
    typedef struct packed
    {
        fbo_op_t op;                      // operation kind
        logic [ADDR_W-1:0] addr;          // byte address or sector address
        logic [DATA_W-1:0] data;          // write data
    } fbo_req_t;
    // pin carrier toward the device
    typedef struct packed
    {
        logic chip_sel_n;                 // chip select, low active
        logic out_en_n;                   // output enable, low active
        logic write_en_n;                 // write enable, low active
        logic reset_n;                    // hardware reset, low active
        logic high_voltage_level;         // request reset pin at high voltage
        logic [ADDR_W-1:0] addr_in;       // address pins
    } fbo_pins_t;
    // ======================================================
    // controller states, gray along idle-setup-strobe-hold
    typedef enum logic [2:0]
    {
        FBO_IDLE = 3'b000,                // bus idle, all strobes high
        FBO_SETUP = 3'b001,               // address and data settle
        FBO_STROBE = 3'b011,              // strobes active
        FBO_HOLD = 3'b010,                // strobes released
        FBO_RST = 3'b110                  // reset pin held low / recovery
    } fbo_state_t;
endpackage

// ---- fbo_host.sv ----
// module: host-side controller driving the parallel flash pins
`timescale 1ns/10ps
// Function
// R01 - read: select and output enable low
// R02 - write enable high throughout reads
// R03 - write: select, write enable low
// R04 - output enable high releases data bus
// R05 - reset low floats device data
// R06 - device starts in array-read mode
// R07 - plain read returns stored byte
// R08 - array-read holds until command written
// R09 - command register has no address
// R10 - each write latches command, address, data
// R11 - bypass program two writes, standard four
// R12 - erase sector, sector group, or chip
// R13 - upper address bits choose sector
// R14 - autoselect reads return identifier codes
// R15 - autoselect reads use normal read cycle
// R16 - busy reads return status bits
// R17 - protect: bit six low, high voltage
// R18 - unprotect: bit six high
// R19 - reset pulse aborts, floats, returns read
// R20 - sector address on highest bits
// R21 - twenty-one address, eight data lines
// R22 - address on fall, data on rise
module fbo_host
    import fbo_pkg::*;
#(
    parameter int ACC_CYCLES = ACC_CYC,   // read access wait
    parameter int WP_CYCLES = WP_CYC,     // write pulse width
    parameter int RP_CYCLES = RP_CYC,     // reset pulse width
    parameter int RH_CYCLES = RH_CYC      // recovery after reset
)
(
    input wire logic ref_clk,                  // 200 MHz clock
    input wire logic reset,                    // async reset, high active
    input wire logic req_valid,                // request offered
    output logic req_ready,                    // request taken this cycle
    input wire fbo_req_t req,                  // request contents
    output logic rsp_valid,                    // one-cycle completion pulse
    output logic [DATA_W-1:0] rsp_data,        // read byte
    output fbo_pins_t pins,                    // control and address pins
    output logic [DATA_W-1:0] byte_bus_out,    // data driven to device
    output logic byte_bus_oe,                  // high while host drives data
    input wire logic [DATA_W-1:0] byte_bus_in, // data pins as seen
    input wire logic operation_done_n          // device ready/busy pin
);
    // ======================================================
    // state
    fbo_state_t state, next_state;             // sequencer state
    fbo_req_t cur, next_cur;                   // request in flight
    logic [CNT_W-1:0] cnt, next_cnt;           // phase counter
    logic [DATA_W-1:0] next_rsp_data;          // captured read
    logic next_rsp_valid;                      // completion next
    fbo_pins_t next_pins;                      // pin values next
    logic [DATA_W-1:0] next_bus_out;           // write data next
    logic next_bus_oe;                         // data drive next
    logic [DATA_W-1:0] din_s1, din_s2;         // data pin synchroniser
    logic busy_s1, busy_s2;                    // ready/busy synchroniser

    // is this a write-type access
    function automatic logic is_write(input fbo_op_t op);
        is_write = (op == FBO_OP_WRITE) || (op == FBO_OP_PROTECT) || (op == FBO_OP_UNPROTECT);
    endfunction

    // protect/unprotect address: sector bits kept, low select bits forced
    function automatic logic [ADDR_W-1:0] prot_addr(input fbo_req_t r);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[ADDR_W-1:SECT_LSB] = r.addr[ADDR_W-1:SECT_LSB];       // R13 R20
        a[BIT_SIX] = (r.op == FBO_OP_UNPROTECT);               // R17 R18
        a[BIT_ONE] = 1'b1;                                     // R17 R18
        a[BIT_ZERO] = 1'b0;                                    // R17 R18
        prot_addr = a;
    endfunction

    // request taken only when idle
    assign req_ready = (state == FBO_IDLE);

    // ======================================================
    // input synchronisers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            din_s1 <= 8'h00;
            din_s2 <= 8'h00;
            busy_s1 <= 1'b1;
            busy_s2 <= 1'b1;
        end
        else
        begin
            din_s1 <= byte_bus_in;
            din_s2 <= din_s1;
            busy_s1 <= operation_done_n;
            busy_s2 <= busy_s1;
        end
    end

    // ======================================================
    // sequencer next values
    always_comb
    begin
        next_state = state;
        next_cur = cur;
        next_cnt = cnt;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_pins = pins;
        next_bus_out = byte_bus_out;
        next_bus_oe = byte_bus_oe;
        case (state)
            FBO_IDLE:
            begin
                // strobes high, bus released
                next_pins.chip_sel_n = 1'b1;
                next_pins.out_en_n = 1'b1;
                next_pins.write_en_n = 1'b1;
                next_pins.reset_n = 1'b1;
                next_pins.high_voltage_level = 1'b0;
                next_bus_oe = 1'b0;
                if (req_valid)
                begin
                    next_cur = req;
                    next_cnt = '0;
                    if (req.op == FBO_OP_RESET)
                    begin
                        // reset pulse: all strobes don't care, held high
                        next_pins.reset_n = 1'b0;          // R05 R19
                        next_state = FBO_RST;
                    end
                    else
                    begin
                        // address settles first; it is latched on the later fall
                        next_pins.addr_in = (req.op == FBO_OP_PROTECT
                            || req.op == FBO_OP_UNPROTECT) ? prot_addr(req) : req.addr; // R22
                        next_pins.high_voltage_level = (req.op == FBO_OP_PROTECT
                            || req.op == FBO_OP_UNPROTECT);                              // R17
                        next_bus_out = req.data;
                        next_bus_oe = is_write(req.op);    // R04
                        next_state = FBO_SETUP;
                    end
                end
            end
            FBO_SETUP:
            begin
                // assert strobes
                next_pins.chip_sel_n = 1'b0;
                if (is_write(cur.op))
                begin
                    next_pins.write_en_n = 1'b0;           // R03
                    next_pins.out_en_n = 1'b1;             // R03
                end
                else
                begin
                    next_pins.out_en_n = 1'b0;             // R01 R07 R14 R15 R16
                    next_pins.write_en_n = 1'b1;           // R02
                end
                next_state = FBO_STROBE;
            end
            FBO_STROBE:
            begin
                // hold strobe for access or pulse width
                next_cnt = cnt + 1'b1;
                if (is_write(cur.op) ? (cnt >= CNT_W'(WP_CYCLES))
                    : (cnt >= CNT_W'(ACC_CYCLES + 2)))
                begin
                    // data stays on the bus past the rising edge
                    next_pins.write_en_n = 1'b1;           // R10 R22
                    next_pins.out_en_n = 1'b1;             // R04
                    next_pins.chip_sel_n = 1'b1;
                    if (!is_write(cur.op))
                    begin
                        next_rsp_data = din_s2;            // R07
                    end
                    next_state = FBO_HOLD;
                end
            end
            FBO_HOLD:
            begin
                // release data one cycle after strobes rise
                next_bus_oe = 1'b0;
                next_pins.high_voltage_level = 1'b0;
                next_rsp_valid = 1'b1;
                next_state = FBO_IDLE;
            end
            FBO_RST:
            begin
                // hold reset low, then wait recovery
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(RP_CYCLES - 1))
                begin
                    next_pins.reset_n = 1'b1;              // R06 R19
                end
                if (cnt >= CNT_W'(RP_CYCLES + RH_CYCLES - 1))
                begin
                    next_rsp_valid = 1'b1;
                    next_state = FBO_IDLE;
                end
            end
            default:
            begin
                next_state = FBO_IDLE;
            end
        endcase
    end

    // ======================================================
    // sequencer registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= FBO_IDLE;
            cur <= '0;
            cnt <= '0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            pins <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
                      reset_n: 1'b1, high_voltage_level: 1'b0, addr_in: '0};
            byte_bus_out <= 8'h00;
            byte_bus_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cur <= next_cur;
            cnt <= next_cnt;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            pins <= next_pins;
            byte_bus_out <= next_bus_out;
            byte_bus_oe <= next_bus_oe;
        end
    end
endmodule // fbo_host

// ---- fbo_host_asserts.sv ----
// checker: pin timing properties of the flash controller
`timescale 1ns/10ps
module fbo_host_asserts
    import fbo_pkg::*;
#(
    parameter int ACC_CYCLES = ACC_CYC, // read wait
    parameter int WP_CYCLES = WP_CYC,   // write pulse
    parameter int RP_CYCLES = RP_CYC,   // reset pulse
    parameter int RH_CYCLES = RH_CYC    // reset recovery
)
(
    input wire logic ref_clk,                   // clock
    input wire logic reset,                     // async reset
    input wire logic req_valid,                 // offered
    input wire logic req_ready,                 // idle
    input wire fbo_req_t req,                   // request
    input wire logic rsp_valid,                 // done pulse
    input wire logic [DATA_W-1:0] rsp_data,     // read byte
    input wire fbo_pins_t pins,                 // device pins
    input wire logic [DATA_W-1:0] byte_bus_out, // host data
    input wire logic byte_bus_oe,               // host drives
    input wire logic [DATA_W-1:0] byte_bus_in,  // data seen
    input wire logic operation_done_n           // busy pin
);
    // ====
    // helper: length of a strobe or reset pulse
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [CNT_W-1:0] run, next_run; // cycles low so far
    wire take = req_valid && req_ready; // request accepted
    always_comb
        next_run = (!pins.chip_sel_n || !pins.reset_n) ? run + 1'b1 : '0;
    always_ff @(posedge ref_clk or posedge reset)
        if (reset)
            run <= '0;
        else
            run <= next_run;
    sequence rd_strobe;
        !pins.chip_sel_n && !pins.out_en_n && pins.write_en_n && !byte_bus_oe;
    endsequence
    sequence wr_strobe;
        !pins.chip_sel_n && !pins.write_en_n && pins.out_en_n && byte_bus_oe;
    endsequence
    // ====
    // properties
    rd_start_a: assert property (take && req.op == FBO_OP_READ |=>
        pins.chip_sel_n && pins.addr_in == $past(req.addr) ##1 rd_strobe)
        else $error("read start wrong");
    wr_start_a: assert property (take && req.op == FBO_OP_WRITE |=>
        byte_bus_oe && byte_bus_out == $past(req.data)
        && pins.addr_in == $past(req.addr) ##1 wr_strobe) else $error("write start wrong");
    prot_pins_a: assert property (take
        && req.op inside {FBO_OP_PROTECT, FBO_OP_UNPROTECT} |=>
        pins.high_voltage_level && pins.addr_in[BIT_SIX] == ($past(req.op) == FBO_OP_UNPROTECT)
        && pins.addr_in[BIT_ONE] && !pins.addr_in[BIT_ZERO]
        && ((pins.addr_in ^ $past(req.addr)) >> SECT_LSB) == '0
        ##1 (wr_strobe and pins.high_voltage_level)) else $error("protect pins wrong");
    read_we_a: assert property (!pins.out_en_n |-> pins.write_en_n && !byte_bus_oe)
        else $error("write strobe during read");
    strobe_len_a: assert property ($rose(pins.chip_sel_n) |->
        run == ($past(pins.write_en_n) ? ACC_CYCLES + 3 : WP_CYCLES + 1))
        else $error("strobe length wrong");
    rst_len_a: assert property ($rose(pins.reset_n) |-> run == RP_CYCLES)
        else $error("reset pulse length wrong");
    done_idle_a: assert property (rsp_valid |-> req_ready && pins.chip_sel_n
        && pins.reset_n && !byte_bus_oe) else $error("done while bus busy");
endmodule // fbo_host_asserts
bind fbo_host fbo_host_asserts #(.ACC_CYCLES(ACC_CYCLES), .WP_CYCLES(WP_CYCLES),
    .RP_CYCLES(RP_CYCLES), .RH_CYCLES(RH_CYCLES)) u_asserts (.ref_clk(ref_clk),
    .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .byte_bus_out(byte_bus_out),
    .byte_bus_oe(byte_bus_oe), .byte_bus_in(byte_bus_in),
    .operation_done_n(operation_done_n));

// ---- fbo_flash_model.sv ----
// behavioural flash answering the controller
`timescale 1ns/10ps
module fbo_flash_model
    import fbo_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5c // arbitrary value
)
(
    input wire fbo_pins_t pins,     // control and address
    input wire logic [7:0] bus_out, // host data
    input wire logic bus_oe,        // host drives
    output logic [7:0] bus_in,      // resolved data
    output logic done_n = 1'b1      // low while busy
);
    bit [7:0] mem_n [0:2097151];       // inverted array, erased reads ff
    bit [31:0] prot;                   // sector locks
    logic [20:0] a_lat;                // write address
    logic [7:0] q, pd;                 // read value, last program byte
    logic sel = 0, by = 0, au = 0, pg = 0; // modes start in array read
    logic er = 0, ms = 0;              // erase armed, more sectors may follow
    int st = 0;                        // unlock step
    wire rst_lo = !pins.reset_n && !pins.high_voltage_level;
    wire drv = !rst_lo && !pins.chip_sel_n && !pins.out_en_n && pins.write_en_n;
    // ====
    // reset pulse drops back to array read
    always @(posedge rst_lo)
    begin
        {by, au, pg, er, ms} = 5'h00;
        st = 0;
    end
    // erase one sector unless it is locked
    task automatic ers(input logic [4:0] s);
        if (!prot[s])
            for (int i = 0; i < 65536; i++)
                mem_n[{s, i[15:0]}] = 8'h00;
    endtask
    // address latched as the strobe falls
    always @(negedge pins.write_en_n)
    begin
        a_lat = pins.addr_in;
        sel = !pins.chip_sel_n && !rst_lo;
    end
    // command decode as the strobe rises
    always @(posedge pins.write_en_n)
    begin
        if (!sel)
            st = st;
        else if (pins.high_voltage_level && a_lat[1:0] == 2'h2)
            prot[a_lat[20:16]] = !a_lat[6];
        else if (pg && !prot[a_lat[20:16]])
        begin
            mem_n[a_lat] = ~bus_out;
            pd = bus_out;
            pg = 0;
            done_n = 1'b0;
            done_n <= #200 1'b1;
        end
        else if (pg)
            pg = 0; // locked sector kept
        else if (bus_out == 8'hf0)
            au = 0;
        else if (by && bus_out == 8'ha0)
            pg = 1;
        else if (ms && bus_out == 8'h30)
            ers(a_lat[20:16]);
        else if (st < 2)
        begin
            st = (bus_out == (st == 0 ? 8'haa : 8'h55)) ? st + 1 : 0;
            ms = 0;
        end
        else
        begin
            pg = !er && bus_out == 8'ha0;
            au = au || bus_out == 8'h90;
            by = by || bus_out == 8'h20;
            if (er && bus_out == 8'h10)
                for (int s = 0; s < 32; s++)
                    ers(s[4:0]);
            ms = er && bus_out == 8'h30;
            if (ms)
                ers(a_lat[20:16]);
            er = bus_out == 8'h80;
            st = 0;
        end
    end
    // data pins: host data while host drives, drive on read, else a changed level
    always @*
    begin
        q = au ? ID_CODE : ~mem_n[pins.addr_in];
        if (!done_n)
            q = {~pd[7], 7'h00};
        bus_in = bus_oe ? bus_out : drv ? q : ~q;
    end
endmodule // fbo_flash_model

// ---- tb.sv ----
// testbench: flash controller against a behavioural flash
`timescale 1ns/10ps
module tb;
    import fbo_pkg::*;
    localparam logic [7:0] ID = 8'h5c; // arbitrary value
    logic ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0;
    fbo_req_t req = '0;
    logic req_ready, rsp_valid, byte_bus_oe, done_n;
    logic [7:0] rsp_data, byte_bus_out, byte_bus_in;
    fbo_pins_t pins;
    int n_mismatch = 0, n_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    fbo_host #(.ACC_CYCLES(2), .WP_CYCLES(2), .RP_CYCLES(2), .RH_CYCLES(2)) DUT (
        .ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
        .byte_bus_out(byte_bus_out), .byte_bus_oe(byte_bus_oe),
        .byte_bus_in(byte_bus_in), .operation_done_n(done_n));
    fbo_flash_model #(.ID_CODE(ID)) u_flash (.pins(pins), .bus_out(byte_bus_out),
        .bus_oe(byte_bus_oe), .bus_in(byte_bus_in), .done_n(done_n));
    // ====
    // shared tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input fbo_op_t op, input logic [20:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        req = '{op, a, d};
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 60)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("completion", {7'h00, rsp_valid}, 8'h01);
    endtask
    task automatic rd(input logic [20:0] a, input logic [7:0] exp, input string what);
        xfer(FBO_OP_READ, a, 8'h00);
        chk(what, rsp_data, exp);
    endtask
    task automatic cmd3(input logic [7:0] c);
        xfer(FBO_OP_WRITE, 21'h000555, 8'haa);
        xfer(FBO_OP_WRITE, 21'h0002aa, 8'h55);
        xfer(FBO_OP_WRITE, 21'h000555, c);
    endtask
    task automatic wait_ready;
        int n;
        for (n = 0; done_n !== 1'b1 && n < 100; n++)
            @(negedge ref_clk);
        chk("ready pin", {7'h00, done_n}, 8'h01);
    endtask
    // ====
    // scenarios
    task automatic t_program;
        rd(21'h012345, 8'hff, "erased byte");
        xfer(FBO_OP_WRITE, 21'h012345, 8'h00);
        rd(21'h012345, 8'hff, "array after stray write");
        cmd3(8'ha0);
        xfer(FBO_OP_WRITE, 21'h012345, 8'h5a);
        rd(21'h012345, 8'h80, "busy status");
        wait_ready;
        rd(21'h012345, 8'h5a, "programmed byte");
        cmd3(8'h20);
        xfer(FBO_OP_WRITE, 21'h000000, 8'ha0);
        xfer(FBO_OP_WRITE, 21'h1f0001, 8'hc3);
        rd(21'h1f0001, 8'h00, "bypass busy status");
        wait_ready;
        rd(21'h1f0001, 8'hc3, "bypass byte");
        $display("test program done");
    endtask
    task automatic t_autosel;
        xfer(FBO_OP_RESET, 21'h000000, 8'h00);
        cmd3(8'h90);
        rd(21'h000000, ID, "identifier");
        xfer(FBO_OP_RESET, 21'h000000, 8'h00);
        rd(21'h012345, 8'h5a, "array after reset");
        $display("test autoselect done");
    endtask
    task automatic t_protect;
        xfer(FBO_OP_PROTECT, 21'h05abcd, 8'h00);
        cmd3(8'ha0);
        xfer(FBO_OP_WRITE, 21'h050010, 8'h11);
        rd(21'h050010, 8'hff, "locked sector");
        xfer(FBO_OP_UNPROTECT, 21'h05abcd, 8'h00);
        cmd3(8'ha0);
        xfer(FBO_OP_WRITE, 21'h050010, 8'h11);
        wait_ready;
        rd(21'h050010, 8'h11, "unlocked sector");
        $display("test protect done");
    endtask
    task automatic t_erase;
        xfer(FBO_OP_PROTECT, 21'h1f0000, 8'h00);
        cmd3(8'h80);
        xfer(FBO_OP_WRITE, 21'h000555, 8'haa);
        xfer(FBO_OP_WRITE, 21'h0002aa, 8'h55);
        xfer(FBO_OP_WRITE, 21'h050000, 8'h30);
        xfer(FBO_OP_WRITE, 21'h010000, 8'h30);
        rd(21'h050010, 8'hff, "first erased sector");
        rd(21'h012345, 8'hff, "second erased sector");
        cmd3(8'ha0);
        xfer(FBO_OP_WRITE, 21'h0a0000, 8'h3c);
        wait_ready;
        rd(21'h0a0000, 8'h3c, "byte before chip erase");
        cmd3(8'h80);
        cmd3(8'h10);
        rd(21'h0a0000, 8'hff, "chip erased byte");
        rd(21'h1f0001, 8'hc3, "locked byte kept");
        $display("test erase done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence, then a watchdog well past its length
    initial
    begin
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        t_program;
        t_autosel;
        t_protect;
        t_erase;
        tally_and_finish;
    end
    initial
    begin
        #40000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // tb
